// ---- hdl/arq_core.sv ----
// Purpose: result bytes, control b, pin input disable and auto trigger of the converter
// Assumes: analog core gives a signed or unsigned 11-bit difference sample on request
// Notes: conversion time is a fixed count; prescaler is out of scope
//
// Behaviour
// - a finished conversion writes its 10-bit result into high and low bytes.
// - reading the low byte freezes both bytes until the high byte is read.
// - right alignment puts bits 9:8 in high 1:0, bits 7:0 low.
// - left alignment puts bits 9:2 high, bits 1:0 in low 7:6.
// - unipolar mode saturates when positive input is not above negative.
// - bipolar mode returns two's complement, nine bits plus sign.
// - unipolar mode gives the full ten bits.
// - polarity reversal swaps the differential input pair.
// - control b bits 4:3 read zero and ignore writes.
// - trigger source acts only while auto trigger is enabled.
// - auto trigger starts on the rising edge of the selected flag.
// - switching from a clear source to a set source is an edge.
// - selecting free running creates no trigger event by itself.
// - source codes 1 to 6 map to the listed trigger sources.
// - pin disable bits 5:0 force the pin input read to zero.
// - changing left alignment changes the presented bytes at once.
// - writing one to auto trigger enable turns auto triggering on.
// - done flag sets on completion with the update; writing one clears.
`timescale 1ns/10ps
module arq_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [arq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog core
    input wire logic [10:0] ana_diff,
    output logic ana_start,
    output logic ana_swap,
    output logic ana_bipolar,
    // trigger sources: 1 comparator, 2 ext int 0, 3 cmp a, 4 ovf, 5 cmp b, 6 pin change
    input wire logic [5:0] trig_flags,
    // pins
    input wire logic [5:0] pin_raw,
    output logic [5:0] pin_buf_off
);
    import arq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum {ARQ_IDLE, ARQ_BUSY} arq_state_t;
    arq_state_t state_reg;
    logic [7:0] ctrl_a_reg;
    logic [7:0] mux_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] dis_reg;
    logic [9:0] result_reg;
    logic lock_reg;
    logic [3:0] cnt_reg;
    logic [7:0] rdata_reg;
    logic start_reg;
    logic [5:0] buf_off_reg;
    logic swap_reg;
    logic bip_reg;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic wr_a, wr_mux, wr_b, wr_dis;
    logic rd_lo, rd_hi;
    assign wr_a = reg_wr && (reg_addr == OFF_CTRL_A);
    assign wr_mux = reg_wr && (reg_addr == OFF_MUX);
    assign wr_b = reg_wr && (reg_addr == OFF_CTRL_B);
    assign wr_dis = reg_wr && (reg_addr == OFF_DIS);
    assign rd_lo = reg_rd && (reg_addr == OFF_RES_LO);
    assign rd_hi = reg_rd && (reg_addr == OFF_RES_HI);

    logic enabled, auto_en, left_al;
    assign enabled = ctrl_a_reg[CA_EN];
    assign auto_en = ctrl_a_reg[CA_ATE];
    assign left_al = mux_reg[MX_LAR];

    ////////////////////////////////////////////////////////////////////////
    // trigger
    logic trig_pulse;
    logic [6:0] src_flags;
    // code 0 slot carries the done flag so the decode stays complete
    assign src_flags = {trig_flags, ctrl_a_reg[CA_DONE]};
    arq_trig u_trig (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .src_sel(ctrl_b_reg[2:0]),
        .src_flags(src_flags),
        .trig_pulse(trig_pulse)
    );

    logic conv_end, free_run, auto_start, sw_start, go;
    logic en_next;
    // enable written in the same cycle as start must still launch that conversion
    assign en_next = wr_a ? reg_wdata[CA_EN] : enabled;
    assign conv_end = (state_reg == ARQ_BUSY) && (cnt_reg == 4'h0);
    assign free_run = auto_en && (ctrl_b_reg[2:0] == TS_FREE) && conv_end;
    assign auto_start = auto_en && (trig_pulse || free_run);
    assign sw_start = wr_a && reg_wdata[CA_START];
    assign go = en_next && (state_reg == ARQ_IDLE || conv_end) && (auto_start || sw_start);

    ////////////////////////////////////////////////////////////////////////
    // sample shaping
    logic [9:0] sample;
    logic neg;
    assign neg = ana_diff[10];
    // unipolar: a non-positive difference saturates to reference; bipolar keeps sign
    assign sample = ctrl_b_reg[CB_BIN] ? {ana_diff[10], ana_diff[9:1]}
                  : (neg || ana_diff[9:0] == RES_ZERO) ? RES_SAT : ana_diff[9:0];

    logic commit;
    // held pair drops a late result rather than tearing it
    assign commit = conv_end && !lock_reg;

    ////////////////////////////////////////////////////////////////////////
    // read mux, alignment evaluated live
    logic [7:0] lo_view, hi_view, rd_mux;
    assign lo_view = left_al ? {result_reg[1:0], 6'h00} : result_reg[7:0];
    assign hi_view = left_al ? result_reg[9:2] : {6'h00, result_reg[9:8]};
    logic [5:0] pin_view;
    assign pin_view = pin_raw & ~dis_reg[5:0];
    logic [7:0] ctrl_a_view;
    assign ctrl_a_view = {ctrl_a_reg[7], (state_reg == ARQ_BUSY), ctrl_a_reg[5:0]};
    always_comb begin
        unique case (reg_addr)
            OFF_CTRL_A: rd_mux = ctrl_a_view;
            OFF_MUX: rd_mux = mux_reg;
            OFF_CTRL_B: rd_mux = ctrl_b_reg & CB_WMASK;
            OFF_RES_LO: rd_mux = lo_view;
            OFF_RES_HI: rd_mux = hi_view;
            OFF_DIS: rd_mux = dis_reg;
            OFF_PIN: rd_mux = {2'b00, pin_view[5:2] & ~dis_reg[5:2], pin_view[1:0]};
            default: rd_mux = RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control a with done flag: set wins over write-one clear
    logic done_next;
    assign done_next = commit ? 1'b1 : ((wr_a && reg_wdata[CA_DONE]) ? 1'b0 : ctrl_a_reg[CA_DONE]);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_a_reg <= RST_BYTE;
        end else begin
            if (wr_a) begin
                ctrl_a_reg <= {reg_wdata[7], 1'b0, reg_wdata[5], done_next, reg_wdata[3:0]};
            end else begin
                ctrl_a_reg[CA_DONE] <= done_next;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mux_reg <= RST_BYTE;
            ctrl_b_reg <= RST_BYTE;
            dis_reg <= RST_BYTE;
        end else begin
            if (wr_mux) mux_reg <= reg_wdata & MUX_WMASK;
            if (wr_b) ctrl_b_reg <= reg_wdata & CB_WMASK;
            if (wr_dis) dis_reg <= reg_wdata & DIS_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ARQ_IDLE;
            cnt_reg <= 4'h0;
        end else if (!en_next) begin
            state_reg <= ARQ_IDLE;
            cnt_reg <= 4'h0;
        end else if (go) begin
            state_reg <= ARQ_BUSY;
            cnt_reg <= CONV_CYCLES;
        end else begin
            unique case (state_reg)
                ARQ_IDLE: cnt_reg <= 4'h0;
                ARQ_BUSY: begin
                    if (conv_end) state_reg <= ARQ_IDLE;
                    else cnt_reg <= cnt_reg - 4'h1;
                end
            endcase
        end
    end

    // result and read lock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_reg <= RES_ZERO;
            lock_reg <= 1'b0;
        end else begin
            if (commit) result_reg <= sample;
            if (rd_hi) lock_reg <= 1'b0;
            else if (rd_lo) lock_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= RST_BYTE;
            start_reg <= 1'b0;
            buf_off_reg <= 6'h00;
            swap_reg <= 1'b0;
            bip_reg <= 1'b0;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : RST_BYTE;
            start_reg <= go;
            buf_off_reg <= dis_reg[5:0];
            swap_reg <= ctrl_b_reg[CB_IPR];
            bip_reg <= ctrl_b_reg[CB_BIN];
        end
    end

    assign reg_rdata = rdata_reg;
    assign ana_start = start_reg;
    assign pin_buf_off = buf_off_reg;
    assign ana_swap = swap_reg;
    assign ana_bipolar = bip_reg;
endmodule

// ---- hdl/arq_pkg.sv ----
// Purpose: shared constants for the converter result and trigger register block
// Assumes: byte-wide register port, one clock
// Notes: offsets are byte addresses on the plain register port
package arq_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL_A = 6'h06;
    localparam logic [5:0] OFF_MUX = 6'h07;
    localparam logic [5:0] OFF_CTRL_B = 6'h03;
    localparam logic [5:0] OFF_RES_LO = 6'h04;
    localparam logic [5:0] OFF_RES_HI = 6'h05;
    localparam logic [5:0] OFF_DIS = 6'h14;
    localparam logic [5:0] OFF_PIN = 6'h16;
    // control a fields
    localparam int CA_EN = 7;
    localparam int CA_START = 6;
    localparam int CA_ATE = 5;
    localparam int CA_DONE = 4;
    // mux register fields
    localparam int MX_LAR = 5;
    // control b fields
    localparam int CB_BIN = 7;
    localparam int CB_IPR = 5;
    localparam logic [7:0] CB_WMASK = 8'hE7;
    localparam logic [7:0] DIS_WMASK = 8'h3F;
    localparam logic [7:0] MUX_WMASK = 8'hEF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RES_SAT = 10'h3FF;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam logic [3:0] CONV_CYCLES = 4'hD;
    // trigger source codes
    localparam logic [2:0] TS_FREE = 3'h0;
    localparam int TS_NUM = 7;
endpackage

// ---- hdl/arq_trig.sv ----
// Purpose: auto-trigger source select and rising edge detection
// Assumes: source flags synchronous to core_clk
// Notes: edge is taken on the selected signal, so a source switch can make one
`timescale 1ns/10ps
module arq_trig (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic [2:0] src_sel,
    input wire logic [6:0] src_flags,
    // result
    output logic trig_pulse
);
    import arq_pkg::*;
    logic sel_reg;
    logic sel_now;
    logic [7:0] flags_ext;
    assign flags_ext = {1'b0, src_flags};
    // free running has no edge of its own here: its restart comes from conv_end in the core, not the done flag
    assign sel_now = (src_sel == TS_FREE) ? 1'b0 : flags_ext[src_sel];
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_reg <= 1'b0;
        end else begin
            sel_reg <= sel_now;
        end
    end
    // rising edge of the selected flag, including one made by switching source
    assign trig_pulse = sel_now & ~sel_reg;
endmodule

// ---- dv/arq_core_chk.sv ----
// Purpose: port checker for the converter register block
// Assumes: one clock, synchronous reset
// Notes: align bit is tracked from mux writes
`timescale 1ns/10ps
module arq_core_chk (
    // clock, reset, bus
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [arq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // outputs
    input wire logic ana_start,
    input wire logic ana_swap,
    input wire logic ana_bipolar,
    input wire logic [5:0] pin_buf_off
);
    import arq_pkg::*;
    logic lar_reg;
    wire cb_wr = reg_wr && reg_addr == OFF_CTRL_B;
    wire dis_wr = reg_wr && reg_addr == OFF_DIS;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk) begin
        if (sys_rst) lar_reg <= 1'b0;
        else if (reg_wr && reg_addr == OFF_MUX) lar_reg <= reg_wdata[MX_LAR];
    end
    ////////////////////////////////////////////////////////////////////////
    property p_cb_res; reg_rd && reg_addr == OFF_CTRL_B |=> reg_rdata[4:3] == 2'h0; endproperty
    a_cb_res: assert property (p_cb_res) else $error("control b spare bits nonzero");
    property p_pin_off; reg_rd && reg_addr == OFF_PIN |=> (reg_rdata[5:0] & pin_buf_off) == 6'h00; endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin reads one");
    property p_bin; $changed(ana_bipolar) |-> $past(cb_wr) || $past(cb_wr, 2); endproperty
    a_bin: assert property (p_bin) else $error("bipolar changed without write");
    property p_swap; $changed(ana_swap) |-> $past(cb_wr) || $past(cb_wr, 2); endproperty
    a_swap: assert property (p_swap) else $error("swap changed without write");
    property p_start; ana_start |=> !ana_start [*8]; endproperty
    a_start: assert property (p_start) else $error("start retriggered while busy");
    property p_buf; $changed(pin_buf_off) |-> $past(dis_wr) || $past(dis_wr, 2); endproperty
    a_buf: assert property (p_buf) else $error("buffer off changed without write");
    property p_hi_right; reg_rd && reg_addr == OFF_RES_HI && !lar_reg |=> reg_rdata[7:2] == 6'h00; endproperty
    a_hi_right: assert property (p_hi_right) else $error("right aligned high byte upper bits");
    property p_lo_left; reg_rd && reg_addr == OFF_RES_LO && lar_reg |=> reg_rdata[5:0] == 6'h00; endproperty
    a_lo_left: assert property (p_lo_left) else $error("left aligned low byte lower bits");
    c_start: cover property (ana_start);
    c_left_hi: cover property (reg_rd && reg_addr == OFF_RES_HI && lar_reg);
    c_pin: cover property (reg_rd && reg_addr == OFF_PIN && pin_buf_off != 6'h00);
endmodule
bind arq_core arq_core_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ana_start(ana_start),
    .ana_swap(ana_swap), .ana_bipolar(ana_bipolar), .pin_buf_off(pin_buf_off));

// ---- dv/adc_result_and_trigger_regs_bench.sv ----
// Purpose: self-checking bench for the converter register block
// Assumes: analog core modelled by driving ana_diff
// Notes: waits of 16 to 20 cycles cover the fixed 14-cycle conversion
`timescale 1ns/10ps
module adc_result_and_trigger_regs_bench;
    import arq_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [10:0] ana_diff = 11'h000;
    logic [5:0] trig_flags = 6'h00;
    logic [5:0] pin_raw = 6'h00;
    logic [7:0] reg_rdata;
    logic ana_start;
    logic ana_swap;
    logic ana_bipolar;
    logic [5:0] pin_buf_off;
    logic [7:0] v;
    logic [5:0] offs [4] = '{OFF_CTRL_B, OFF_RES_LO, OFF_RES_HI, OFF_DIS};
    int miscompares = 0;
    int total_checks = 0;
    int starts = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (ana_start === 1'b1) starts <= starts + 1;
    arq_core i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ana_diff(ana_diff), .ana_start(ana_start),
        .ana_swap(ana_swap), .ana_bipolar(ana_bipolar), .trig_flags(trig_flags), .pin_raw(pin_raw),
        .pin_buf_off(pin_buf_off));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [5:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic conv(input logic [10:0] d);
        ana_diff <= d;
        wr(OFF_CTRL_A, 8'hC0);
        repeat (16) @(posedge core_clk);
    endtask
    task automatic settle(input logic [7:0] d, input string what, input logic [7:0] inc);
        repeat (20) @(posedge core_clk);
        chk(what, d + inc, 8'(starts));
    endtask
    function automatic logic [15:0] pair(input logic [10:0] d, input logic bipolar_select, input logic lar);
        logic [9:0] q;
        q = bipolar_select ? d[10:1] : ((d[10] || d == 11'h000) ? RES_SAT : d[9:0]);
        return lar ? {q, 6'h00} : {6'h00, q};
    endfunction
    task automatic finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        finish_test;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] e;
        logic [7:0] d;
        logic [10:0] x;
        logic [2:0] m;
        void'($urandom(67));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (offs[i]) begin
            rd(offs[i]);
            chk("reset_value", 8'h00, v);
        end
        wr(OFF_CTRL_B, 8'hFF);
        rd(OFF_CTRL_B);
        chk("ctrl_b", CB_WMASK, v);
        chk("bipolar", 8'h01, {7'h00, ana_bipolar});
        chk("swap", 8'h01, {7'h00, ana_swap});
        repeat (4) begin
            d = 8'($urandom);
            pin_raw <= 6'($urandom);
            wr(OFF_DIS, d);
            rd(OFF_DIS);
            chk("disable", d & DIS_WMASK, v);
            chk("buf_off", {2'h0, d[5:0]}, {2'h0, pin_buf_off});
            rd(OFF_PIN);
            chk("pin_read", {2'h0, pin_raw & ~d[5:0]}, v);
        end
        for (int i = 0; i < 8; i++) begin
            x = (i == 0) ? 11'h000 : (i == 1) ? 11'h400 : 11'($urandom);
            m = (i < 2) ? 3'h0 : 3'($urandom);
            wr(OFF_MUX, {2'h0, m[0], 5'h00});
            wr(OFF_CTRL_B, {m[1], 7'h00});
            conv(x);
            e = pair(x, m[1], m[0]);
            rd(OFF_RES_LO);
            chk("res_low", e[7:0], v);
            rd(OFF_RES_HI);
            chk("res_high", e[15:8], v);
            rd(OFF_CTRL_A);
            chk("done", 8'h10, v & 8'h10);
            wr(OFF_CTRL_A, 8'h90);
            rd(OFF_CTRL_A);
            chk("done_clear", 8'h00, v & 8'h10);
        end
        wr(OFF_MUX, 8'h00);
        wr(OFF_CTRL_B, 8'h00);
        conv(11'h155);
        rd(OFF_RES_LO);
        chk("held_low", 8'h55, v);
        wr(OFF_CTRL_A, 8'h90);
        conv(11'h2AA);
        rd(OFF_CTRL_A);
        chk("held_done", 8'h00, v & 8'h10);
        rd(OFF_RES_HI);
        chk("held_high", 8'h01, v);
        wr(OFF_MUX, 8'h20);
        rd(OFF_RES_HI);
        chk("left_high", 8'h55, v);
        wr(OFF_CTRL_B, 8'h01);
        d = 8'(starts);
        trig_flags <= 6'h01;
        settle(d, "auto_off", 8'h00);
        trig_flags <= 6'h00;
        wr(OFF_CTRL_A, 8'hA0);
        for (int c = 1; c < 7; c++) begin
            wr(OFF_CTRL_B, 8'(c));
            d = 8'(starts);
            trig_flags <= 6'h01 << (c - 1);
            settle(d, "auto_start", 8'h01);
            trig_flags <= 6'h00;
        end
        trig_flags <= 6'h02;
        repeat (20) @(posedge core_clk);
        d = 8'(starts);
        wr(OFF_CTRL_B, 8'h02);
        settle(d, "switch_edge", 8'h01);
        d = 8'(starts);
        wr(OFF_CTRL_B, 8'h00);
        settle(d, "free_select", 8'h00);
        // free running: one software start, then a restart at each completion
        d = 8'(starts);
        wr(OFF_CTRL_A, 8'hE0);
        settle(d, "free_run", 8'h02);
        wr(OFF_CTRL_A, 8'h80);
        repeat (20) @(posedge core_clk);
        finish_test;
    end
endmodule
